// >>> shared/pst_pkg.sv
// Purpose: Shared constants for the power-up serial report link
// Assumes: 40 MHz core clock, one report per power cycle at the default address
// Notes:   Timing counts derive from the clock rate
package pst_pkg;

    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned BAUD            = 1200;
    // Bit period rounded down; error stays far inside UART tolerance
    localparam int unsigned BIT_CYCLES      = CLK_HZ / BAUD;
    localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
    localparam int unsigned POWERUP_MS      = 100;
    // Longest time, so rounded down
    localparam int unsigned POWERUP_CYCLES  = (CLK_HZ / 1000) * POWERUP_MS;

    localparam logic [3:0] FRAME_BITS   = 4'ha;
    localparam logic [2:0] LAST_FIELD   = 3'h2;

    localparam logic [7:0] DEFAULT_ADDR = 8'h30;
    localparam logic [7:0] CH_TAB       = 8'h09;
    localparam logic [7:0] CH_SPACE     = 8'h20;
    localparam logic [7:0] CH_CR        = 8'h0d;
    localparam logic [7:0] KIND_CHAR    = 8'h3b;
    localparam logic [7:0] CHK_OFS      = 8'h20;
    localparam logic [7:0] CRC_INIT     = 8'hfc;
    localparam logic [7:0] CRC_POLY     = 8'h9c;
    localparam logic [7:0] CRC_OFS      = 8'h30;
    localparam logic [7:0] SUM_INIT     = 8'h00;

    function automatic logic [7:0] pst_crc_byte(input logic [7:0] crc,
                                                input logic [7:0] b);
        logic [7:0] c;
        c = crc ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

endpackage

// >>> shared/pst_if.sv
// Purpose: Carrier joining sensor end and logger end
// Assumes: Sensor always drives the data line; logger switches power
// Notes:   Power is looped to the sensor's reset by the bench
interface pst_if;
    logic sdata;
    logic power;
    modport dev  (output sdata, input  power);
    modport host (input  sdata, output power);
endinterface

// >>> rtl/pst_dev.sv
// Purpose: Sensor end: power-up report framer and serial transmitter
// Assumes: Reset release is power applied; fields arrive as ASCII
// Notes:   One frame per reset at the default address, then the other bus mode is entered
module pst_dev
    import pst_pkg::*;
#(
    parameter int unsigned P_POWERUP_CYCLES = POWERUP_CYCLES,
    parameter int unsigned P_BIT_CYCLES     = BIT_CYCLES
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    input  wire logic [7:0] i_bus_addr,
    input  wire logic       i_meas_done,
    input  wire logic [7:0] i_data,
    input  wire logic       i_data_last,
    input  wire logic       i_data_valid,
    output logic            o_data_ready,
    output logic            o_measuring,
    output logic            o_other_mode,
    pst_if.dev              link
);

    typedef enum logic [3:0] {
        ST_MEAS, ST_TAB, ST_FIELD, ST_SEP, ST_CR,
        ST_KIND, ST_CHK, ST_CRC, ST_FLUSH, ST_DONE
    } pst_state_t;

    pst_state_t  st_reg;
    pst_state_t  st_next;
    logic [31:0] pu_cnt_reg;
    logic [2:0]  fld_reg;
    logic [7:0]  sum_reg;
    logic [7:0]  crc_reg;
    logic [9:0]  tx_sh_reg;
    logic [3:0]  tx_bits_reg;
    logic [31:0] tx_baud_reg;
    logic        line_reg;

    // Two-entry buffer, entries are {last, byte}
    logic [8:0]  buf_mem_reg [2];
    logic        buf_wr_reg;
    logic        buf_rd_reg;
    logic [1:0]  buf_cnt_reg;

    wire         buf_in_ok  = (buf_cnt_reg != 2'h2) && (st_reg != ST_DONE);
    wire         buf_push   = i_data_valid && buf_in_ok;
    wire         buf_valid  = (buf_cnt_reg != 2'h0);
    wire  [8:0]  buf_head   = buf_mem_reg[buf_rd_reg];
    wire         tx_busy    = (tx_bits_reg != 4'h0);
    wire         addr_dflt  = (i_bus_addr == DEFAULT_ADDR);
    wire         pu_expired = (pu_cnt_reg >= P_POWERUP_CYCLES - 1);
    wire         baud_tick  = (tx_baud_reg == P_BIT_CYCLES - 1);
    wire  [7:0]  chk_char   = {2'b00, sum_reg[5:0]} + CHK_OFS;
    wire  [7:0]  crc_char   = {2'b00, crc_reg[7:2]} + CRC_OFS;

    logic        byte_avail;
    logic [7:0]  tx_byte;
    always_comb begin
        byte_avail = 1'b0;
        tx_byte    = CH_SPACE;
        case (st_reg)
            ST_TAB: begin
                byte_avail = buf_valid;
                tx_byte    = CH_TAB;
            end
            ST_FIELD: begin
                byte_avail = buf_valid;
                tx_byte    = buf_head[7:0];
            end
            ST_SEP: begin
                byte_avail = 1'b1;
                tx_byte    = CH_SPACE;
            end
            ST_CR: begin
                byte_avail = 1'b1;
                tx_byte    = CH_CR;
            end
            ST_KIND: begin
                byte_avail = 1'b1;
                tx_byte    = KIND_CHAR;
            end
            ST_CHK: begin
                byte_avail = 1'b1;
                tx_byte    = chk_char;
            end
            ST_CRC: begin
                byte_avail = 1'b1;
                tx_byte    = crc_char;
            end
            default: begin
                byte_avail = 1'b0;
                tx_byte    = CH_SPACE;
            end
        endcase
    end

    wire         load     = byte_avail && !tx_busy;
    wire         buf_pop  = load && (st_reg == ST_FIELD);
    wire         in_sum   = (st_reg != ST_CHK) && (st_reg != ST_CRC);
    wire         in_crc   = (st_reg != ST_CRC);

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_MEAS: begin
                if (!addr_dflt) begin
                    st_next = ST_DONE;
                end else if (i_meas_done || pu_expired) begin
                    st_next = ST_TAB;
                end
            end
            ST_TAB: begin
                if (load) begin
                    st_next = ST_FIELD;
                end
            end
            ST_FIELD: begin
                if (load && buf_head[8]) begin
                    st_next = (fld_reg == LAST_FIELD) ? ST_CR : ST_SEP;
                end
            end
            ST_SEP: begin
                if (load) begin
                    st_next = ST_FIELD;
                end
            end
            ST_CR: begin
                if (load) begin
                    st_next = ST_KIND;
                end
            end
            ST_KIND: begin
                if (load) begin
                    st_next = ST_CHK;
                end
            end
            ST_CHK: begin
                if (load) begin
                    st_next = ST_CRC;
                end
            end
            ST_CRC: begin
                if (load) begin
                    st_next = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (!tx_busy) begin
                    st_next = ST_DONE;
                end
            end
            default: begin
                st_next = ST_DONE;  // Only a reset leaves this state
            end
        endcase
    end

    // Line low while measuring; shifter bit while a frame is on the wire; otherwise idle high
    wire line_next = (st_reg == ST_MEAS) ? 1'b0 :
                     tx_busy ? tx_sh_reg[0] : 1'b1;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg     <= ST_MEAS;
            pu_cnt_reg <= 32'h0;
            fld_reg    <= 3'h0;
            line_reg   <= 1'b0;
        end else begin
            st_reg     <= st_next;
            line_reg   <= line_next;
            if (st_reg == ST_MEAS) begin
                pu_cnt_reg <= pu_cnt_reg + 32'h1;
            end
            if (buf_pop && buf_head[8]) begin
                fld_reg <= fld_reg + 3'h1;
            end
        end
    end

    // Running check over bytes before the check char, CRC over bytes before the CRC char, as loaded
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sum_reg <= SUM_INIT;
            crc_reg <= CRC_INIT;
        end else if (load) begin
            if (in_sum) begin
                sum_reg <= sum_reg + tx_byte;
            end
            if (in_crc) begin
                crc_reg <= pst_crc_byte(crc_reg, tx_byte);
            end
        end
    end

    // Shifter: start 0, data LSB first, stop 1
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_sh_reg   <= 10'h3ff;
            tx_bits_reg <= 4'h0;
            tx_baud_reg <= 32'h0;
        end else if (load) begin
            tx_sh_reg   <= {1'b1, tx_byte, 1'b0};
            tx_bits_reg <= FRAME_BITS;
            tx_baud_reg <= 32'h0;
        end else if (tx_busy) begin
            if (baud_tick) begin
                tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
                tx_bits_reg <= tx_bits_reg - 4'h1;
                tx_baud_reg <= 32'h0;
            end else begin
                tx_baud_reg <= tx_baud_reg + 32'h1;
            end
        end
    end

    // Buffer lets the producer run ahead while a byte is on the wire
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            buf_mem_reg[0] <= 9'h0;
            buf_mem_reg[1] <= 9'h0;
            buf_wr_reg     <= 1'b0;
            buf_rd_reg     <= 1'b0;
            buf_cnt_reg    <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_mem_reg[buf_wr_reg] <= {i_data_last, i_data};
                buf_wr_reg              <= ~buf_wr_reg;
            end
            if (buf_pop) begin
                buf_rd_reg <= ~buf_rd_reg;
            end
            if (buf_push && !buf_pop) begin
                buf_cnt_reg <= buf_cnt_reg + 2'h1;
            end else if (buf_pop && !buf_push) begin
                buf_cnt_reg <= buf_cnt_reg - 2'h1;
            end
        end
    end

    assign o_data_ready = buf_in_ok;
    assign o_measuring  = (st_reg == ST_MEAS);
    assign o_other_mode = (st_reg == ST_DONE);
    assign link.sdata   = line_reg;

endmodule

// >>> rtl/pst_host.sv
// Purpose: Logger end: sensor power control and report receiver
// Assumes: Line is synchronous to the core clock
// Notes:   No byte buffering; each byte is a one-cycle pulse
module pst_host
    import pst_pkg::*;
#(
    parameter int unsigned P_BIT_CYCLES = BIT_CYCLES
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_power_req,
    output logic [7:0]      o_byte,
    output logic            o_byte_valid,
    output logic            o_frame_err,
    pst_if.host             link
);

    typedef enum logic [2:0] {
        H_OFF, H_WAIT_HIGH, H_IDLE, H_START, H_BITS, H_STOP
    } pst_hstate_t;

    pst_hstate_t hs_reg;
    pst_hstate_t hs_next;
    logic [31:0] cnt_reg;
    logic [2:0]  bit_reg;
    logic [7:0]  sh_reg;
    logic        prev_reg;
    logic        pwr_reg;
    logic [7:0]  byte_reg;
    logic        valid_reg;
    logic        err_reg;

    wire line     = link.sdata;
    wire fall     = prev_reg && !line;
    // Half of this instance's bit, so a short test bit still samples mid-bit
    localparam int unsigned HALF_CYCLES = P_BIT_CYCLES / 2;
    wire half_hit = (cnt_reg == HALF_CYCLES - 1);
    wire full_hit = (cnt_reg == P_BIT_CYCLES - 1);
    wire samp     = (hs_reg == H_START) ? half_hit : full_hit;

    always_comb begin
        hs_next = hs_reg;
        case (hs_reg)
            H_OFF:       hs_next = pwr_reg ? H_WAIT_HIGH : H_OFF;
            // Pre-frame lows are signalling, not characters
            H_WAIT_HIGH: hs_next = line ? H_IDLE : H_WAIT_HIGH;
            H_IDLE:      hs_next = fall ? H_START : H_IDLE;
            H_START: begin
                if (samp) begin
                    hs_next = line ? H_IDLE : H_BITS;
                end
            end
            H_BITS: begin
                if (samp && bit_reg == 3'h7) begin
                    hs_next = H_STOP;
                end
            end
            H_STOP: begin
                if (samp) begin
                    hs_next = H_IDLE;
                end
            end
            default: hs_next = H_OFF;
        endcase
        if (!pwr_reg) begin
            hs_next = H_OFF;  // Power cycle re-arms the report
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hs_reg    <= H_OFF;
            cnt_reg   <= 32'h0;
            bit_reg   <= 3'h0;
            sh_reg    <= 8'h0;
            prev_reg  <= 1'b0;
            pwr_reg   <= 1'b0;
            byte_reg  <= 8'h0;
            valid_reg <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            hs_reg    <= hs_next;
            prev_reg  <= line;
            pwr_reg   <= i_power_req;
            valid_reg <= 1'b0;
            if (hs_reg != hs_next || samp || hs_reg == H_IDLE) begin
                cnt_reg <= 32'h0;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
            if (hs_reg == H_BITS && samp) begin
                sh_reg  <= {line, sh_reg[7:1]};  // LSB first
                bit_reg <= bit_reg + 3'h1;
            end
            if (hs_reg == H_STOP && samp) begin
                byte_reg  <= sh_reg;
                valid_reg <= 1'b1;
                err_reg   <= !line;
            end
        end
    end

    assign o_byte       = byte_reg;
    assign o_byte_valid = valid_reg;
    assign o_frame_err  = err_reg;
    assign link.power   = pwr_reg;

endmodule

// >>> tb/pst_link_asserts.sv
// Purpose: Line checks on the power-up serial report link
// Assumes: Sensor reset follows the power line
// Notes:   Run counters measure level lengths in clock cycles
module pst_link_asserts #(
    parameter int unsigned P_POWERUP_CYCLES = 200,
    parameter int unsigned P_BIT_CYCLES     = 16
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic sdata,
    input wire logic power
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RISE_MAX = P_POWERUP_CYCLES + 8;
    localparam int BITS     = P_BIT_CYCLES;
    logic        last_reg;
    logic        seen_reg;
    logic        start_reg;
    logic [19:0] run_reg;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_reg  <= 1'b0;
            seen_reg  <= 1'b0;
            start_reg <= 1'b0;
            run_reg   <= 20'h00001;
        end else begin
            last_reg  <= sdata;
            seen_reg  <= power & (seen_reg | sdata);
            start_reg <= power & (start_reg | (last_reg & ~sdata));
            run_reg   <= (sdata != last_reg) ? 20'h00001 : run_reg + 20'h1;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_meas_low;
        !sdata ##1 !sdata;
    endsequence
    sequence s_start;
        $fell(sdata) && power;
    endsequence
    chk_off_line_low: assert property (!power |-> !sdata)
        else $error("line high while unpowered");
    chk_drop_low: assert property ($fell(power) |=> s_meas_low)
        else $error("line not low after power drop");
    chk_meas_low: assert property ($rose(power) |-> s_meas_low)
        else $error("line not low while measuring");
    chk_rise_bound: assert property (
        $rose(power) |-> ##[1:RISE_MAX] sdata)
        else $error("line not raised in time");
    chk_start_hold: assert property (s_start |-> ##1 (!sdata)[*8])
        else $error("start bit too short");
    chk_low_whole: assert property (
        $rose(sdata) && seen_reg |-> run_reg % BITS == 0)
        else $error("low run not whole bits");
    chk_low_max: assert property (
        $rose(sdata) && seen_reg |-> run_reg <= 9 * BITS)
        else $error("stop bit missing");
    chk_high_min: assert property (
        (s_start and start_reg) |-> run_reg >= BITS)
        else $error("high run shorter than a bit");
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the power-up serial report link
// Assumes: Short bit and power-up counts keep frames brief
// Notes:   Bench decodes the line and checks the bytes the host end receives
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pst_pkg::*;
    localparam int unsigned PU  = 200;
    localparam int unsigned BIT = 16;
    logic       i_core_clk;
    logic       i_rst_b;
    logic       i_power_req;
    logic       i_meas_done;
    logic       i_data_valid;
    logic       i_data_last;
    logic [7:0] i_data;
    logic [7:0] i_bus_addr;
    logic       dev_rst_b;
    logic       o_data_ready;
    logic       o_measuring;
    logic       o_other_mode;
    logic [7:0] o_byte;
    logic       o_byte_valid;
    logic       o_frame_err;
    int         errors;
    int         compares;
    logic [7:0] exp_q[$];
    logic [8:0] feed_q[$];
    pst_if link ();
    // Power off is the sensor's reset
    assign dev_rst_b = i_rst_b & link.power;
    pst_dev #(.P_POWERUP_CYCLES(PU), .P_BIT_CYCLES(BIT)) u_pst_dev (
        .i_core_clk(i_core_clk), .i_rst_b(dev_rst_b),
        .i_bus_addr(i_bus_addr), .i_meas_done(i_meas_done),
        .i_data(i_data), .i_data_last(i_data_last),
        .i_data_valid(i_data_valid), .o_data_ready(o_data_ready),
        .o_measuring(o_measuring), .o_other_mode(o_other_mode),
        .link(link));
    pst_host #(.P_BIT_CYCLES(BIT)) u_pst_host (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_power_req(i_power_req), .o_byte(o_byte),
        .o_byte_valid(o_byte_valid), .o_frame_err(o_frame_err),
        .link(link));
    pst_link_asserts #(.P_POWERUP_CYCLES(PU), .P_BIT_CYCLES(BIT))
        u_pst_link_asserts (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .sdata(link.sdata), .power(link.power));
    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    task automatic check(input string what, input logic [7:0] e,
                         input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] b);
        c = c ^ b;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic build(input int len);
        logic [7:0] b;
        logic [7:0] sum;
        logic [7:0] crc;
        int         n;
        exp_q = {CH_TAB};
        feed_q = {};
        for (int f = 0; f < 3; f++) begin
            n = (len == 0) ? $urandom_range(3, 1) : len;
            for (int k = 0; k < n; k++) begin
                b = 8'($urandom_range(126, 33));
                feed_q.push_back({k == n - 1, b});
                exp_q.push_back(b);
            end
            exp_q.push_back(f == 2 ? CH_CR : CH_SPACE);
        end
        exp_q.push_back(KIND_CHAR);
        sum = 8'h00;
        foreach (exp_q[i]) sum += exp_q[i];
        exp_q.push_back({2'b00, sum[5:0]} + CHK_OFS);
        crc = CRC_INIT;
        foreach (exp_q[i]) crc = crc_step(crc, exp_q[i]);
        exp_q.push_back({2'b00, crc[7:2]} + CRC_OFS);
    endtask
    task automatic feed();
        int k;
        k = 0;
        while (k < feed_q.size()) begin
            {i_data_last, i_data} <= feed_q[k];
            i_data_valid <= 1'b1;
            @(posedge i_core_clk);
            if (o_data_ready === 1'b1) k++;
        end
        i_data_valid <= 1'b0;
    endtask
    task automatic get_char(output logic [7:0] c);
        int t;
        t = 0;
        while (link.sdata !== 1'b0 && t < 4000) begin
            @(posedge i_core_clk);
            t++;
        end
        check("start_wait", 8'h01, {7'h0, t < 4000});
        repeat (BIT / 2) @(posedge i_core_clk);
        check("start", 8'h00, {7'h0, link.sdata});
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge i_core_clk);
            c[i] = link.sdata;
        end
        repeat (BIT) @(posedge i_core_clk);
        check("stop", 8'h01, {7'h0, link.sdata});
    endtask
    task automatic wait_byte();
        int t;
        t = 0;
        do begin
            @(posedge i_core_clk);
            t++;
        end while (o_byte_valid !== 1'b1 && t < 4000);
        check("byte_wait", 8'h01, {7'h0, t < 4000});
    endtask
    task automatic power_up(input logic [7:0] addr, input int early);
        int         t;
        int         lim;
        logic [7:0] exp_b;
        i_power_req <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        i_bus_addr <= addr;
        i_power_req <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        exp_b = {7'h0, addr == DEFAULT_ADDR};
        check("measuring", exp_b, {7'h0, o_measuring});
        check("meas_line", 8'h00, {7'h0, link.sdata});
        t = 3;
        while (link.sdata !== 1'b1 && t < PU + 40) begin
            i_meas_done <= (t == early);
            @(posedge i_core_clk);
            t++;
        end
        i_meas_done <= 1'b0;
        lim = (early > 0) ? early + 10 : PU + 10;
        check("rise", 8'h01, {7'h0, t <= lim});
    endtask
    task automatic quiet(input string what);
        logic q;
        q = 1'b1;
        repeat (20 * BIT) begin
            @(posedge i_core_clk);
            q &= (link.sdata === 1'b1);
        end
        check(what, 8'h01, {7'h0, q});
        check("other_mode", 8'h01, {7'h0, o_other_mode});
        check("ready", 8'h00, {7'h0, o_data_ready});
    endtask
    task automatic frame_test(input int len, input int early);
        logic [7:0] c;
        build(len);
        power_up(DEFAULT_ADDR, early);
        fork
            feed();
            foreach (exp_q[i]) begin
                get_char(c);
                if (i == exp_q.size() - 1) begin
                    check("crc", exp_q[i], c);
                end else if (i == exp_q.size() - 2) begin
                    check("chk", exp_q[i], c);
                end else begin
                    check("char", exp_q[i], c);
                end
            end
            foreach (exp_q[j]) begin
                wait_byte();
                check("host_byte", exp_q[j], o_byte);
                check("host_err", 8'h00, {7'h0, o_frame_err});
            end
        join
        quiet("idle_after");
        $display("frame test done, %0d chars", exp_q.size());
    endtask
    task automatic skip_test(input logic [7:0] addr);
        build(1);
        power_up(addr, 0);
        {i_data_last, i_data} <= feed_q[0];
        i_data_valid <= 1'b1;
        quiet("suppressed");
        i_data_valid <= 1'b0;
        $display("skip test done, addr %h", addr);
    endtask
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge i_core_clk);
        errors++;
        $display("MISMATCH watchdog expected done seen timeout");
        stop_test();
    end
    initial begin
        i_rst_b = 1'b0;
        i_power_req = 1'b0;
        i_meas_done = 1'b0;
        i_data_valid = 1'b0;
        i_data_last = 1'b0;
        i_data = 8'h00;
        i_bus_addr = DEFAULT_ADDR;
        errors = 0;
        compares = 0;
        void'($urandom(32'he560));
        repeat (12) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        frame_test(1, 0);
        frame_test(0, 20);
        frame_test(0, 0);
        skip_test(8'h31);
        skip_test(8'($urandom_range(255, 49)));
        frame_test(3, 0);
        stop_test();
    end
endmodule
